// File: rtl/mie_pkg.sv
// Package: constants, register map and opcodes of the instruction execution unit
// Function
// - Sum-with-carry to accumulator adds acc, memory byte, carry; range, zero, spill, carry.
// - Sum-with-carry to memory adds acc, memory byte, carry into memory; same four flags.
// - Plain sums add acc with memory or immediate into acc; no carry-in; four flags.
// - Plain sum to memory adds acc and memory byte into memory; four flags.
// - Conjunction to acc ands acc with memory or immediate; only Z changes.
// - Conjunction to memory ands memory with acc into memory; only Z changes.
// - Call pushes PC plus one, loads target into PC, leaves flags alone.
// - Byte clear writes zero into memory byte; no flag changes.
// - Bit clear zeroes one selected bit, keeps others, no flag changes.
// - Watchdog clear zeroes counter and prescaler, clears powerdown and timeout flags.
// - Preclear pair clears watchdog and flags only after both ran; else records itself.
// - Invert flips memory byte into memory or acc only; only Z changes.
// - Low nibble over 9 or spill flag adds 6, inner spill inverts flag; else zero.
// - High nibble plus spill above 9 or C adds 6 and sets C; result to memory.
// - Minus one decrements memory byte into memory or acc only; only Z changes.
// - Power-down stops execution and turns the system clock off.
// - Power-down keeps RAM, clears watchdog, sets PD, clears TO, advances PC.
// - Operands are 8-bit immediate, 7-bit address, 3-bit bit index, 11-bit target.
package mie_pkg;
    // ==========================================================
    // Operand widths
    localparam int IMM_W      = 8;
    localparam int MADDR_W    = 7;
    localparam int BIT_W      = 3;
    localparam int PC_W       = 11;
    localparam int STACK_D    = 4;
    localparam int SP_W       = 2;
    localparam int WDT_W      = 8;
    localparam int PRE_W      = 8;
    localparam int OP_W       = 5;

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] REG_INSTR    = 8'h00;
    localparam logic [7:0] REG_OPERAND  = 8'h04;
    localparam logic [7:0] REG_ACC      = 8'h08;
    localparam logic [7:0] REG_PC       = 8'h0c;
    localparam logic [7:0] REG_STATUS   = 8'h10;
    localparam logic [7:0] REG_MEM_ADDR = 8'h14;
    localparam logic [7:0] REG_MEM_DATA = 8'h18;
    localparam logic [7:0] REG_WATCHDOG = 8'h1c;
    localparam logic [7:0] REG_WAKE     = 8'h20;

    // ==========================================================
    // Field positions
    localparam int F_OP_LSB     = 0;
    localparam int F_BIT_LSB    = 8;
    localparam int F_MADDR_LSB  = 16;
    localparam int F_IMM_LSB    = 0;
    localparam int F_TGT_LSB    = 16;
    localparam int F_WDT_LSB    = 0;
    localparam int F_PRE_LSB    = 8;
    localparam int F_SEEN1_BIT  = 16;
    localparam int F_SEEN2_BIT  = 17;
    localparam int F_HALT_BIT   = 18;
    localparam int F_SP_LSB     = 19;

    // Status bits
    localparam int ST_C     = 0;
    localparam int ST_SPILL = 1;
    localparam int ST_Z     = 2;
    localparam int ST_RANGE = 3;
    localparam int ST_PD  = 4;
    localparam int ST_TO  = 5;
    localparam int ST_TC1 = 6;
    localparam int ST_TC2 = 7;

    // ==========================================================
    // Reset values and BCD constants
    localparam logic [7:0]      RST_ACC    = 8'h00;
    localparam logic [10:0]     RST_PC     = 11'h000;
    localparam logic [7:0]      RST_STATUS = 8'h00;
    localparam logic [4:0]      BCD_LIMIT  = 5'h09;
    localparam logic [3:0]      BCD_FIX    = 4'h6;

    // ==========================================================
    // Opcodes
    typedef enum logic [OP_W-1:0] {
        op_sum_carry_to_acc       = 5'h00,
        op_sum_with_carry_to_memory = 5'h01,
        op_plain_sum_acc_mem      = 5'h02,
        op_plain_sum_acc_imm      = 5'h03,
        op_plain_sum_to_memory    = 5'h04,
        op_conj_acc_mem           = 5'h05,
        op_conj_acc_imm           = 5'h06,
        op_conjunction_to_memory  = 5'h07,
        op_call                   = 5'h08,
        op_clear_byte             = 5'h09,
        op_clear_bit              = 5'h0a,
        op_watchdog_clear         = 5'h0b,
        op_watchdog_preclear_first  = 5'h0c,
        op_watchdog_preclear_second = 5'h0d,
        op_invert_memory          = 5'h0e,
        op_invert_to_acc          = 5'h0f,
        op_bcd_fixup              = 5'h10,
        op_minus_one_memory       = 5'h11,
        op_minus_one_to_acc       = 5'h12,
        op_power_down             = 5'h13
    } mie_op_t;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_load = 2'b01,
        st_exec = 2'b10
    } mie_state_t;
endpackage

// File: rtl/mie_ram.sv
// Data memory with registered read data
`timescale 1ns/100ps
module mie_ram
    import mie_pkg::*;
#(
    parameter int AW = MADDR_W,
    parameter int DW = IMM_W
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic [AW-1:0] addr,
    input  wire logic          we,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [(1<<AW)-1:0][DW-1:0] mem;
        logic [DW-1:0]              q;
    } mie_ram_s_t;

    mie_ram_s_t s;
    mie_ram_s_t next_s;

    always_comb begin
        next_s = s;
        next_s.q = s.mem[addr];
        if (we) begin
            next_s.mem[addr] = wdata;
        end
    end

    // Contents survive reset so power-down state can be inspected
    always_ff @(posedge clk) begin
        if (rst) begin
            s.q <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign rdata = s.q;
endmodule

// File: rtl/mie_core.sv
// Instruction execution unit with Avalon-MM register access
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module mie_core
    import mie_pkg::*;
#(
    parameter int WDT_BITS = WDT_W,
    parameter int PRE_BITS = PRE_W
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             halted,
    output logic             sys_clk_en
);
    // ==========================================================
    // State
    typedef struct packed {
        mie_state_t                        state;
        logic [OP_W-1:0]                   op;
        logic [MADDR_W-1:0]                maddr;
        logic [BIT_W-1:0]                  bitidx;
        logic [IMM_W-1:0]                  imm;
        logic [PC_W-1:0]                   target;
        logic [7:0]                        acc;
        logic [PC_W-1:0]                   pc;
        logic [7:0]                        flags;
        logic [STACK_D-1:0][PC_W-1:0]      stack;
        logic [SP_W-1:0]                   sp;
        logic [WDT_BITS-1:0]               wdt;
        logic [PRE_BITS-1:0]               pre;
        logic                              seen1;
        logic                              seen2;
        logic                              halted;
        logic [MADDR_W-1:0]                dbg_addr;
        logic                              rd_pend;
        logic                              ack;
        logic [31:0]                       rdata;
    } mie_core_s_t;

    mie_core_s_t s;
    mie_core_s_t next_s;

    logic [MADDR_W-1:0] ram_addr;
    logic               ram_we;
    logic [7:0]         ram_wdata;
    logic [7:0]         ram_q;

    // ==========================================================
    // Adder: {carry, nibble spill, signed range, sum}
    function automatic logic [10:0] mie_add(input logic [7:0] a, input logic [7:0] b,
                                            input logic ci);
        logic [4:0] lo;
        logic [8:0] full;
        logic       ov;
        lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        ov   = (a[7] == b[7]) && (full[7] != a[7]);
        return {full[8], lo[4], ov, full[7:0]};
    endfunction

    // ==========================================================
    // Execution and bus decode
    logic [10:0] add_r;
    logic [7:0]  res;
    logic        wr_acc;
    logic        wr_mem;
    logic        upd_arith;
    logic        upd_z;
    logic        wdt_clr;
    logic        wdt_wrap;
    logic [3:0]  lo_nib;
    logic [4:0]  hi_sum;
    logic        spill;
    logic [31:0] rd_mux;

    always_comb begin
        next_s    = s;
        add_r     = '0;
        res       = 8'h00;
        wr_acc    = 1'b0;
        wr_mem    = 1'b0;
        upd_arith = 1'b0;
        upd_z     = 1'b0;
        wdt_clr   = 1'b0;
        wdt_wrap  = 1'b0;
        lo_nib    = 4'h0;
        hi_sum    = 5'h00;
        spill     = 1'b0;
        rd_mux    = 32'h0000_0000;
        ram_we    = 1'b0;
        ram_wdata = 8'h00;
        ram_addr  = (s.state == st_idle) ? s.dbg_addr : s.maddr;
        next_s.ack = 1'b0;

        // Watchdog keeps counting in power-down, like its own oscillator would
        next_s.pre = s.pre + 1'b1;
        if (&s.pre) begin
            next_s.wdt = s.wdt + 1'b1;
            wdt_wrap   = &s.wdt;
        end

        unique case (avs_address)
            REG_INSTR: begin
                rd_mux[F_OP_LSB +: OP_W]       = s.op;
                rd_mux[F_BIT_LSB +: BIT_W]     = s.bitidx;
                rd_mux[F_MADDR_LSB +: MADDR_W] = s.maddr;
            end
            REG_OPERAND: begin
                rd_mux[F_IMM_LSB +: IMM_W] = s.imm;
                rd_mux[F_TGT_LSB +: PC_W]  = s.target;
            end
            REG_ACC:      rd_mux[7:0]            = s.acc;
            REG_PC:       rd_mux[PC_W-1:0]       = s.pc;
            REG_STATUS:   rd_mux[7:0]            = s.flags;
            REG_MEM_ADDR: rd_mux[MADDR_W-1:0]    = s.dbg_addr;
            REG_MEM_DATA: rd_mux[7:0]            = ram_q;
            REG_WATCHDOG: begin
                rd_mux[F_WDT_LSB +: WDT_BITS] = s.wdt;
                rd_mux[F_PRE_LSB +: PRE_BITS] = s.pre;
                rd_mux[F_SEEN1_BIT]           = s.seen1;
                rd_mux[F_SEEN2_BIT]           = s.seen2;
                rd_mux[F_HALT_BIT]            = s.halted;
                rd_mux[F_SP_LSB +: SP_W]      = s.sp;
                // Top of return stack, otherwise invisible to software
                rd_mux[F_SP_LSB + SP_W +: PC_W] = s.stack[s.sp - 1'b1];
            end
            default:      rd_mux = 32'h0000_0000;
        endcase

        unique case (s.state)
            st_idle: begin
                if (!s.ack && avs_write) begin
                    next_s.ack = 1'b1;
                    unique case (avs_address)
                        REG_INSTR: begin
                            // Stopped core accepts the write but runs nothing
                            if (!s.halted) begin
                                next_s.op     = avs_writedata[F_OP_LSB +: OP_W];
                                next_s.bitidx = avs_writedata[F_BIT_LSB +: BIT_W];
                                next_s.maddr  = avs_writedata[F_MADDR_LSB +: MADDR_W];
                                next_s.state  = st_load;
                                next_s.ack    = 1'b0;
                            end
                        end
                        REG_OPERAND: begin
                            next_s.imm    = avs_writedata[F_IMM_LSB +: IMM_W];
                            next_s.target = avs_writedata[F_TGT_LSB +: PC_W];
                        end
                        REG_ACC:      next_s.acc      = avs_writedata[7:0];
                        REG_PC:       next_s.pc       = avs_writedata[PC_W-1:0];
                        REG_STATUS:   next_s.flags    = avs_writedata[7:0];
                        REG_MEM_ADDR: next_s.dbg_addr = avs_writedata[MADDR_W-1:0];
                        REG_MEM_DATA: begin
                            ram_we    = 1'b1;
                            ram_wdata = avs_writedata[7:0];
                        end
                        REG_WAKE:     next_s.halted   = 1'b0;
                        default:      next_s.ack      = 1'b1;
                    endcase
                end else if (!s.ack && avs_read) begin
                    // Extra cycle lets the memory read settle before capture
                    if (!s.rd_pend) begin
                        next_s.rd_pend = 1'b1;
                    end else begin
                        next_s.rd_pend = 1'b0;
                        next_s.rdata   = rd_mux;
                        next_s.ack     = 1'b1;
                    end
                end
            end
            st_load: begin
                next_s.state = st_exec;
            end
            st_exec: begin
                next_s.state = st_idle;
                next_s.ack   = 1'b1;
                next_s.pc    = s.pc + 1'b1;
                unique case (s.op)
                    op_sum_carry_to_acc: begin
                        add_r     = mie_add(s.acc, ram_q, s.flags[ST_C]);
                        wr_acc    = 1'b1;
                        upd_arith = 1'b1;
                    end
                    op_sum_with_carry_to_memory: begin
                        add_r     = mie_add(s.acc, ram_q, s.flags[ST_C]);
                        wr_mem    = 1'b1;
                        upd_arith = 1'b1;
                    end
                    op_plain_sum_acc_mem: begin
                        add_r     = mie_add(s.acc, ram_q, 1'b0);
                        wr_acc    = 1'b1;
                        upd_arith = 1'b1;
                    end
                    op_plain_sum_acc_imm: begin
                        add_r     = mie_add(s.acc, s.imm, 1'b0);
                        wr_acc    = 1'b1;
                        upd_arith = 1'b1;
                    end
                    op_plain_sum_to_memory: begin
                        add_r     = mie_add(s.acc, ram_q, 1'b0);
                        wr_mem    = 1'b1;
                        upd_arith = 1'b1;
                    end
                    op_conj_acc_mem: begin
                        res    = s.acc & ram_q;
                        wr_acc = 1'b1;
                        upd_z  = 1'b1;
                    end
                    op_conj_acc_imm: begin
                        res    = s.acc & s.imm;
                        wr_acc = 1'b1;
                        upd_z  = 1'b1;
                    end
                    op_conjunction_to_memory: begin
                        res    = s.acc & ram_q;
                        wr_mem = 1'b1;
                        upd_z  = 1'b1;
                    end
                    op_call: begin
                        // Fifth nested call overwrites the oldest return address
                        next_s.stack[s.sp] = s.pc + 1'b1;
                        next_s.sp          = s.sp + 1'b1;
                        next_s.pc          = s.target;
                    end
                    op_clear_byte: begin
                        res    = 8'h00;
                        wr_mem = 1'b1;
                    end
                    op_clear_bit: begin
                        res    = ram_q & ~(8'h01 << s.bitidx);
                        wr_mem = 1'b1;
                    end
                    op_watchdog_clear: begin
                        wdt_clr = 1'b1;
                    end
                    op_watchdog_preclear_first: begin
                        if (s.seen2) begin
                            wdt_clr      = 1'b1;
                            next_s.seen2 = 1'b0;
                        end else begin
                            next_s.seen1 = 1'b1;
                        end
                    end
                    op_watchdog_preclear_second: begin
                        if (s.seen1) begin
                            wdt_clr      = 1'b1;
                            next_s.seen1 = 1'b0;
                        end else begin
                            next_s.seen2 = 1'b1;
                        end
                    end
                    op_invert_memory: begin
                        res    = ~ram_q;
                        wr_mem = 1'b1;
                        upd_z  = 1'b1;
                    end
                    op_invert_to_acc: begin
                        res    = ~ram_q;
                        wr_acc = 1'b1;
                        upd_z  = 1'b1;
                    end
                    op_bcd_fixup: begin
                        if (({1'b0, s.acc[3:0]} > BCD_LIMIT) || s.flags[ST_SPILL]) begin
                            lo_nib = s.acc[3:0] + BCD_FIX;
                            spill  = ~s.flags[ST_SPILL];
                        end else begin
                            lo_nib = s.acc[3:0];
                            spill  = 1'b0;
                        end
                        hi_sum = {1'b0, s.acc[7:4]} + {4'h0, spill};
                        if ((hi_sum > BCD_LIMIT) || s.flags[ST_C]) begin
                            res[7:4]           = s.acc[7:4] + BCD_FIX + {3'h0, spill};
                            next_s.flags[ST_C] = 1'b1;
                        end else begin
                            res[7:4] = hi_sum[3:0];
                        end
                        res[3:0] = lo_nib;
                        wr_mem   = 1'b1;
                    end
                    op_minus_one_memory: begin
                        res    = ram_q - 1'b1;
                        wr_mem = 1'b1;
                        upd_z  = 1'b1;
                    end
                    op_minus_one_to_acc: begin
                        res    = ram_q - 1'b1;
                        wr_acc = 1'b1;
                        upd_z  = 1'b1;
                    end
                    op_power_down: begin
                        next_s.halted = 1'b1;
                        wdt_clr       = 1'b1;
                    end
                    default: begin
                        res = 8'h00;
                    end
                endcase
                if (upd_arith) begin
                    res                 = add_r[7:0];
                    next_s.flags[ST_C]     = add_r[10];
                    next_s.flags[ST_SPILL] = add_r[9];
                    next_s.flags[ST_RANGE] = add_r[8];
                end
                // Untouched flags, timer bits included, fall through unchanged
                if (upd_arith || upd_z) begin
                    next_s.flags[ST_Z] = (res == 8'h00);
                end
                if (wr_acc) begin
                    next_s.acc = res;
                end
                ram_we    = wr_mem;
                ram_wdata = res;
            end
            default: begin
                next_s.state = st_idle;
            end
        endcase

        if (wdt_clr) begin
            next_s.wdt          = '0;
            next_s.pre          = '0;
            next_s.flags[ST_TO] = 1'b0;
            next_s.flags[ST_PD] = (s.state == st_exec) && (s.op == op_power_down);
        end
        // Overflow in the clearing cycle still counts
        if (wdt_wrap) begin
            next_s.flags[ST_TO] = 1'b1;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            s       <= '0;
            s.state <= st_idle;
            s.acc   <= RST_ACC;
            s.pc    <= RST_PC;
            s.flags <= RST_STATUS;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Data memory
    mie_ram #(
        .AW (MADDR_W),
        .DW (8)
    ) u_ram (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .addr  (ram_addr),
        .we    (ram_we),
        .wdata (ram_wdata),
        .rdata (ram_q)
    );

    assign avs_readdata    = s.rdata;
    assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
    assign halted          = s.halted;
    assign sys_clk_en      = !s.halted;
endmodule

// File: verification/mie_core_asserts.sv
// Port checker for the instruction execution unit
`timescale 1ns/100ps
module mie_core_asserts
    import mie_pkg::*;
#(
    parameter int WDT_BITS = WDT_W,
    parameter int PRE_BITS = PRE_W
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        halted,
    input wire logic        sys_clk_en
);
    // ==========================================================
    // Bus timing and halt behaviour
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_clk_off: assert property (sys_clk_en == !halted)
        else $error("clock enable not inverse of halt");
    a_halt_entry: assert property ($rose(avs_write) && avs_address == 8'h00 &&
        avs_writedata[4:0] == 5'h13 && !halted |-> ##3 halted) else $error("no halt");
    a_halt_hold: assert property (halted && !(avs_write && avs_address == 8'h20)
        |=> halted) else $error("halt dropped without wake");
    a_wake_clear: assert property (halted && avs_write && avs_address == 8'h20 &&
        avs_waitrequest |=> !halted) else $error("wake ignored");
    a_halt_skip: assert property ($rose(avs_write) && avs_address == 8'h00 && halted
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("halted instr not skipped");
    a_exec_time: assert property ($rose(avs_write) && avs_address == 8'h00 && !halted
        |-> avs_waitrequest[*3] ##1 !avs_waitrequest) else $error("instr answer late");
    a_read_time: assert property ($rose(avs_read)
        |-> avs_waitrequest[*2] ##1 !avs_waitrequest) else $error("read answer late");
    a_write_time: assert property ($rose(avs_write) && avs_address != 8'h00
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("write answer late");
    a_unmapped_zero: assert property ($rose(avs_read) && avs_address == 8'h40
        |-> ##2 avs_readdata == 32'h0) else $error("unmapped read not zero");
endmodule
bind mie_core mie_core_asserts #(.WDT_BITS(WDT_BITS), .PRE_BITS(PRE_BITS)) u_chk (
    .clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .halted(halted), .sys_clk_en(sys_clk_en));

// File: verification/mie_core_tb.sv
// Self-checking bench for the instruction execution unit
`timescale 1ns/100ps
module mie_core_tb;
    logic        clk;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [31:0] rv0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        halted;
    logic        sys_clk_en;
    logic [31:0] rv;
    int          mismatches = 0;
    int          n_compared = 0;
    int          cycles = 0;
    mie_core dut_u (.clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .halted(halted),
        .sys_clk_en(sys_clk_en));
    // ==========================================================
    // Bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic rd, input logic [7:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= rd;
        avs_write     <= !rd;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rv = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    // Vector order: acc, mem, status, imm, then expected acc, mem, status
    task automatic t(input logic [4:0] op, input logic [2:0] b, input logic [55:0] v);
        acc(0, 8'h08, {24'h0, v[55:48]});
        acc(0, 8'h14, 32'h5);
        acc(0, 8'h18, {24'h0, v[47:40]});
        acc(0, 8'h10, {24'h0, v[39:32]});
        acc(0, 8'h0c, 32'h7fe);
        acc(0, 8'h04, {24'h0, v[31:24]});
        acc(0, 8'h00, {16'h5, 5'h0, b, 3'h0, op});
        acc(1, 8'h08, 32'h0);
        chk(rv, {24'h0, v[23:16]});
        acc(1, 8'h18, 32'h0);
        chk(rv, {24'h0, v[15:8]});
        acc(1, 8'h10, 32'h0);
        chk(rv, {24'h0, v[7:0]});
        acc(1, 8'h0c, 32'h0);
        chk(rv, 32'h7ff);
    endtask
    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Clock, timeout and test sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Whole run needs about 900 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        acc(0, 8'h0c, 32'h123);
        acc(0, 8'h04, 32'h07ff0000);
        acc(0, 8'h00, 32'h8);
        acc(1, 8'h0c, 32'h0);
        chk(rv, 32'h7ff);
        acc(1, 8'h1c, 32'h0);
        chk({30'h0, rv[20:19]}, 32'h1);
        chk({21'h0, rv[31:21]}, 32'h124);
        // Prescaler must not move while the clock enable is low
        rv0 = rv;
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
        acc(1, 8'h1c, 32'h0);
        chk({24'h0, rv[15:8] - rv0[15:8]}, 32'h4);
        t(5'h00, 3'h0, 56'h7f00c1008000ca);
        t(5'h01, 3'h0, 56'hff000100ff0007);
        t(5'h02, 3'h0, 56'h8888010010880b);
        t(5'h03, 3'h0, 56'h01550102035500);
        t(5'h04, 3'h0, 56'h10f00000100005);
        t(5'h05, 3'h0, 56'hf00f0b00000f0f);
        t(5'h06, 3'h0, 56'h3c550424245500);
        t(5'h07, 3'h0, 56'h0ff331000f0331);
        t(5'h09, 3'h0, 56'h12a5ff001200ff);
        t(5'h0a, 3'h7, 56'h00ff0000007f00);
        acc(1, 8'h00, 32'h0);
        chk(rv, 32'h0005070a);
        t(5'h0e, 3'h0, 56'h00ff0000000004);
        t(5'h0f, 3'h0, 56'h005a0400a55a00);
        t(5'h10, 3'h0, 56'h9a5500009a0001);
        t(5'h10, 3'h0, 56'h15550600151b06);
        t(5'h11, 3'h0, 56'h00010000000004);
        t(5'h12, 3'h0, 56'h00000400ff0000);
        t(5'h14, 3'h0, 56'h5aa5c3005aa5c3);
        t(5'h0b, 3'h0, 56'h00003000000000);
        acc(1, 8'h1c, 32'h0);
        chk({24'h0, rv[7:0]}, 32'h0);
        t(5'h0c, 3'h0, 56'h00003000000030);
        t(5'h0d, 3'h0, 56'h00003000000000);
        t(5'h13, 3'h0, 56'h00002011000010);
        chk({31'h0, sys_clk_en}, 32'h0);
        acc(0, 8'h00, 32'h3);
        acc(1, 8'h08, 32'h0);
        chk(rv, 32'h0);
        acc(0, 8'h20, 32'h0);
        chk({31'h0, halted}, 32'h0);
        acc(1, 8'h40, 32'h0);
        chk(rv, 32'h0);
        results();
    end
endmodule
